// ### design/sbec_hold_reg.sv
// load-enabled capture register, deliberately without reset
`timescale 1ns/100ps
module sbec_hold_reg #(
  parameter int W = 32
) (
  input wire logic clk_in,
  input wire logic load_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] hold_q;
  logic [W-1:0] hold_d;

  always_comb begin
    hold_d = load_in ? d_in : hold_q;
  end

  // contents survive reset, like the status they belong to
  always_ff @(posedge clk_in) begin
    hold_q <= hold_d;
  end

  assign q_out = hold_q;

endmodule

// ### design/sbec_par_grp.sv
// parity checker for one group of bus lines
`timescale 1ns/100ps
`include "sbec_params.svh"
module sbec_par_grp #(
  parameter int W = 32
) (
  input wire logic [W-1:0] data_in,
  input wire logic par_in,
  output logic fail_out
);

  always_comb begin
    fail_out = ((^data_in) ^ par_in) != `SBEC_PAR_ODD;
  end

endmodule

// ### design/sbec_params.svh
// offsets, field positions and reset values of the bus error capture block
`ifndef SBEC_PARAMS_SVH
`define SBEC_PARAMS_SVH

// register indices on the internal processor register port
`define SBEC_IDX_STATUS 3'h0
`define SBEC_IDX_OUT_ADDR 3'h1
`define SBEC_IDX_OUT_CMD 3'h2
`define SBEC_IDX_IN_CMD 3'h3
`define SBEC_IDX_DATA_HI 3'h4
`define SBEC_IDX_DATA_LO 3'h5

// status flag bit positions
`define SBEC_BIT_MISSING_ACKNOWLEDGE_FLAG 0
`define SBEC_BIT_BADW 1
`define SBEC_BIT_LOST_OUT 2
`define SBEC_BIT_PARITY_ERROR_FLAG 3
`define SBEC_BIT_INCON 4
`define SBEC_BIT_LOST_PARITY_ERROR_FLAG 5
`define SBEC_FLAG_W 6

// outgoing command capture layout
`define SBEC_OC_CMD_LSB 0
`define SBEC_OC_ID_LSB 4
`define SBEC_OC_BE_LSB 8
`define SBEC_OC_LEN_LSB 30

// incoming command capture layout
`define SBEC_IC_CMD_LSB 0
`define SBEC_IC_ID_LSB 4
`define SBEC_IC_PAR_LSB 8

// parity sense: 1'h0 means even parity over each group and its parity line
`define SBEC_PAR_ODD 1'h0

// reset values of the register port outputs
`define SBEC_RDATA_RST 32'h0000_0000
`define SBEC_ACK_RST 1'h0

`endif

// ### design/sbec_pkg.sv
// types shared by the bus error capture block
`include "sbec_params.svh"
package sbec_pkg;

  typedef logic [31:0] sbec_word_t;
  typedef logic [`SBEC_FLAG_W-1:0] sbec_flags_t;

  // register selector, one-hot codes
  typedef enum logic [5:0] {
    SBEC_SEL_NONE     = 6'h00,
    SBEC_SEL_STATUS   = 6'h01,
    SBEC_SEL_OUT_ADDR = 6'h02,
    SBEC_SEL_OUT_CMD  = 6'h04,
    SBEC_SEL_IN_CMD   = 6'h08,
    SBEC_SEL_DATA_HI  = 6'h10,
    SBEC_SEL_DATA_LO  = 6'h20
  } sbec_sel_t;

endpackage

// ### design/sbec_top.sv
// system bus error capture: status flags, outgoing and incoming cycle captures
//
// Functional notes
// R1: unacknowledged own cycle sets flag bit 0, freezes captures
// R2: freeze keeps address cycle info of transaction
// R3: no missing-ack after poison; same cycle both
// R4: poisoned write-back data sets bit 1, freezes captures
// R5: second outgoing error sets lost flag bit 2
// R6: parity checked every cycle; bit 3, freeze input captures
// R7: acknowledged parity failure sets bit 4 with bit 3
// R8: no inconsistent flag once parity flag already set
// R9: parity failure with parity flag set sets bit 5
// R10: flags clear only by writing one
// R11: status flags never initialised by reset
// R12: address capture loads at ack slot while unlocked
// R13: locked keeps first failure, else last acknowledged
// R14: address capture read-only, low bus longword
// R15: command capture: cmd 3:0, id 6:4, bytes 15:8
// R16: length in 31:30, no high byte enables
// R17: input captures load and lock together once
// R18: input command capture holds cmd, id, parity
// R19: raw bus lines 63:32 high, 31:0 low
// R20: outgoing captures unlock when both flags clear
`timescale 1ns/100ps
`include "sbec_params.svh"
module sbec_top
  import sbec_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  // bus observation, all sampled in the ack-due cycle
  // own address cycle, ack due this cycle
  input wire logic own_addr_slot_in,
  // own data cycle, ack due this cycle
  input wire logic own_data_slot_in,
  // any agent's cycle, ack due this cycle
  input wire logic any_cycle_slot_in,
  input wire logic ack_in,
  // own data cycle issued with the bad-write-data command
  input wire logic bad_wdata_in,
  input wire logic [63:0] bus_data_in,
  input wire logic [3:0] bus_cmd_in,
  input wire logic [2:0] bus_id_in,
  input wire logic [2:0] bus_parity_in,
  input wire logic [7:0] own_byte_en_in,
  input wire logic [1:0] own_len_in,
  // internal processor register port
  input wire logic ipr_sel_in,
  input wire logic ipr_wr_in,
  input wire logic [2:0] ipr_index_in,
  input wire logic [31:0] ipr_wdata_in,
  output logic [31:0] ipr_rdata_out,
  output logic ipr_ack_out,
  output logic [5:0] err_flags_out
);

  // bus line groups shared by parity check and captures
  sbec_word_t bus_lo;
  sbec_word_t bus_hi;
  logic [6:0] bus_ctl;

  always_comb begin
    bus_lo = bus_data_in[31:0];
    bus_hi = bus_data_in[63:32];
    bus_ctl = {bus_id_in, bus_cmd_in};
  end

  // parity check, three groups
  logic [2:0] par_fail;
  logic any_par_fail;

  sbec_par_grp #(.W(32)) u_par_lo (
    .data_in(bus_lo),
    .par_in(bus_parity_in[0]),
    .fail_out(par_fail[0])
  );

  sbec_par_grp #(.W(32)) u_par_hi (
    .data_in(bus_hi),
    .par_in(bus_parity_in[1]),
    .fail_out(par_fail[1])
  );

  sbec_par_grp #(.W(7)) u_par_ctl (
    .data_in(bus_ctl),
    .par_in(bus_parity_in[2]),
    .fail_out(par_fail[2])
  );

  always_comb begin
    any_par_fail = |par_fail;
  end

  // register port decode; unmapped indices select nothing
  sbec_sel_t sel;
  logic status_wr;

  always_comb begin
    sel = SBEC_SEL_NONE;
    if (ipr_sel_in) begin
      case (ipr_index_in)
        `SBEC_IDX_STATUS: sel = SBEC_SEL_STATUS;
        `SBEC_IDX_OUT_ADDR: sel = SBEC_SEL_OUT_ADDR;
        `SBEC_IDX_OUT_CMD: sel = SBEC_SEL_OUT_CMD;
        `SBEC_IDX_IN_CMD: sel = SBEC_SEL_IN_CMD;
        `SBEC_IDX_DATA_HI: sel = SBEC_SEL_DATA_HI;
        `SBEC_IDX_DATA_LO: sel = SBEC_SEL_DATA_LO;
        default: sel = SBEC_SEL_NONE;
      endcase
    end
  end

  // status is the only register that takes writes
  always_comb begin
    status_wr = ipr_wr_in && (sel == SBEC_SEL_STATUS);
  end

  // error events
  sbec_flags_t flags_q;
  sbec_flags_t flags_d;
  sbec_flags_t flag_set;
  sbec_flags_t flag_clr;
  logic own_slot;
  logic out_err_ev;
  logic missing_acknowledge_flag_ev;
  logic badw_ev;
  logic parity_error_flag_ev;
  logic out_locked;
  logic in_locked;

  always_comb begin
    own_slot = own_addr_slot_in || own_data_slot_in;
    // address or data cycle of ours that nobody acknowledged
    missing_acknowledge_flag_ev = own_slot && !ack_in; // [R1]
    badw_ev = own_data_slot_in && bad_wdata_in; // [R4]
    out_err_ev = missing_acknowledge_flag_ev || badw_ev;
    parity_error_flag_ev = any_cycle_slot_in && any_par_fail; // [R6]
    // captures stay frozen until both outgoing flags are gone
    out_locked = flags_q[`SBEC_BIT_MISSING_ACKNOWLEDGE_FLAG] || flags_q[`SBEC_BIT_BADW]; // [R20]
    // incoming captures hold until the parity flag is cleared
    in_locked = flags_q[`SBEC_BIT_PARITY_ERROR_FLAG]; // [R17]
  end

  always_comb begin
    flag_set = '0;
    // a poison already recorded suppresses the missing-ack flag
    flag_set[`SBEC_BIT_MISSING_ACKNOWLEDGE_FLAG] = missing_acknowledge_flag_ev && !flags_q[`SBEC_BIT_BADW]; // [R3] [R1]
    flag_set[`SBEC_BIT_BADW] = badw_ev; // [R4] [R3]
    // only the first outgoing error keeps its captures
    flag_set[`SBEC_BIT_LOST_OUT] = out_err_ev && out_locked; // [R5]
    flag_set[`SBEC_BIT_PARITY_ERROR_FLAG] = parity_error_flag_ev; // [R6]
    // acknowledged by someone else, only on the first failure
    flag_set[`SBEC_BIT_INCON] = parity_error_flag_ev && ack_in && !in_locked; // [R7] [R8]
    // a later parity failure only marks the loss
    flag_set[`SBEC_BIT_LOST_PARITY_ERROR_FLAG] = parity_error_flag_ev && in_locked; // [R9]
  end

  always_comb begin
    flag_clr = '0;
    if (status_wr) begin
      // ones clear, zeros leave the flag alone
      flag_clr[`SBEC_BIT_MISSING_ACKNOWLEDGE_FLAG] = ipr_wdata_in[`SBEC_BIT_MISSING_ACKNOWLEDGE_FLAG]; // [R10]
      flag_clr[`SBEC_BIT_BADW] = ipr_wdata_in[`SBEC_BIT_BADW]; // [R10]
      flag_clr[`SBEC_BIT_LOST_OUT] = ipr_wdata_in[`SBEC_BIT_LOST_OUT]; // [R10]
      flag_clr[`SBEC_BIT_PARITY_ERROR_FLAG] = ipr_wdata_in[`SBEC_BIT_PARITY_ERROR_FLAG]; // [R10]
      flag_clr[`SBEC_BIT_INCON] = ipr_wdata_in[`SBEC_BIT_INCON]; // [R10]
      flag_clr[`SBEC_BIT_LOST_PARITY_ERROR_FLAG] = ipr_wdata_in[`SBEC_BIT_LOST_PARITY_ERROR_FLAG]; // [R10]
    end
    // a set in the clearing cycle wins
    flags_d = (flags_q & ~flag_clr) | flag_set; // [R10]
  end

  // no reset on purpose: flags come up arbitrary and survive reset
  // software writes all ones once before trusting them
  always_ff @(posedge clk_in) begin
    flags_q <= flags_d; // [R11]
  end

  // outgoing captures
  logic out_load;
  sbec_word_t out_addr_d;
  sbec_word_t out_cmd_d;
  sbec_word_t out_addr_cap;
  sbec_word_t out_cmd_cap;

  always_comb begin
    // only address cycles load, so a data-cycle failure keeps
    // the address cycle of its own transaction
    // an unacknowledged address cycle still loads, then locks
    out_load = own_addr_slot_in && !out_locked; // [R12] [R13] [R2]
    out_addr_d = bus_lo; // [R14]
    // bits 7 and 29:16 read zero
    out_cmd_d = '0;
    out_cmd_d[`SBEC_OC_CMD_LSB +: 4] = bus_cmd_in; // [R15]
    out_cmd_d[`SBEC_OC_ID_LSB +: 3] = bus_id_in; // [R15]
    out_cmd_d[`SBEC_OC_BE_LSB +: 8] = own_byte_en_in; // [R15]
    out_cmd_d[`SBEC_OC_LEN_LSB +: 2] = own_len_in; // [R16]
  end

  // address and command captures share one load strobe
  sbec_hold_reg #(.W(32)) u_out_addr (
    .clk_in(clk_in),
    .load_in(out_load),
    .d_in(out_addr_d),
    .q_out(out_addr_cap)
  );

  sbec_hold_reg #(.W(32)) u_out_cmd (
    .clk_in(clk_in),
    .load_in(out_load),
    .d_in(out_cmd_d),
    .q_out(out_cmd_cap)
  );

  // incoming captures
  logic in_load;
  sbec_word_t in_cmd_d;
  sbec_word_t in_cmd_cap;
  sbec_word_t data_hi_cap;
  sbec_word_t data_lo_cap;

  always_comb begin
    // clear meeting a new failure: flag stays, captures keep the older cycle
    in_load = parity_error_flag_ev && !in_locked; // [R17]
    // bits 7 and 31:11 read zero
    in_cmd_d = '0;
    in_cmd_d[`SBEC_IC_CMD_LSB +: 4] = bus_cmd_in; // [R18]
    in_cmd_d[`SBEC_IC_ID_LSB +: 3] = bus_id_in; // [R18]
    in_cmd_d[`SBEC_IC_PAR_LSB +: 3] = bus_parity_in; // [R18]
  end

  // one load strobe keeps the three incoming captures together
  sbec_hold_reg #(.W(32)) u_in_cmd (
    .clk_in(clk_in),
    .load_in(in_load),
    .d_in(in_cmd_d),
    .q_out(in_cmd_cap)
  );

  sbec_hold_reg #(.W(32)) u_data_hi (
    .clk_in(clk_in),
    .load_in(in_load),
    .d_in(bus_hi), // [R19]
    .q_out(data_hi_cap)
  );

  sbec_hold_reg #(.W(32)) u_data_lo (
    .clk_in(clk_in),
    .load_in(in_load),
    .d_in(bus_lo), // [R19]
    .q_out(data_lo_cap)
  );

  // read path; writes to capture registers are ignored
  sbec_word_t status_word;
  sbec_word_t rdata_q;
  sbec_word_t rdata_d;
  logic ack_q;
  logic ack_d;
  logic rd_en;

  // status word: flags at their bit positions, upper bits read zero
  always_comb begin
    status_word = '0;
    status_word[`SBEC_BIT_MISSING_ACKNOWLEDGE_FLAG] = flags_q[`SBEC_BIT_MISSING_ACKNOWLEDGE_FLAG];
    status_word[`SBEC_BIT_BADW] = flags_q[`SBEC_BIT_BADW];
    status_word[`SBEC_BIT_LOST_OUT] = flags_q[`SBEC_BIT_LOST_OUT];
    status_word[`SBEC_BIT_PARITY_ERROR_FLAG] = flags_q[`SBEC_BIT_PARITY_ERROR_FLAG];
    status_word[`SBEC_BIT_INCON] = flags_q[`SBEC_BIT_INCON];
    status_word[`SBEC_BIT_LOST_PARITY_ERROR_FLAG] = flags_q[`SBEC_BIT_LOST_PARITY_ERROR_FLAG];
  end

  // every access is answered one cycle later, reads and writes alike
  always_comb begin
    ack_d = ipr_sel_in;
    rd_en = ipr_sel_in && !ipr_wr_in;
    rdata_d = '0;
    if (rd_en) begin
      case (sel)
        SBEC_SEL_STATUS: rdata_d = status_word;
        SBEC_SEL_OUT_ADDR: rdata_d = out_addr_cap; // [R14]
        SBEC_SEL_OUT_CMD: rdata_d = out_cmd_cap;
        SBEC_SEL_IN_CMD: rdata_d = in_cmd_cap;
        SBEC_SEL_DATA_HI: rdata_d = data_hi_cap;
        SBEC_SEL_DATA_LO: rdata_d = data_lo_cap;
        default: rdata_d = '0;
      endcase
    end
  end

  // only the port outputs reset; flags and captures keep their state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= `SBEC_RDATA_RST;
      ack_q <= `SBEC_ACK_RST;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign ipr_rdata_out = rdata_q;
  assign ipr_ack_out = ack_q;
  assign err_flags_out = flags_q;

endmodule

// ### verification/sbec_bus_agent.sv
// other bus agents: acknowledge and parity lines of the sampled cycle
`timescale 1ns/100ps
module sbec_bus_agent (
  input wire logic slot_in,
  input wire logic refuse_in,
  input wire logic [2:0] corrupt_in,
  input wire logic [63:0] data_in,
  input wire logic [3:0] cmd_in,
  input wire logic [2:0] id_in,
  output logic ack_out,
  output logic [2:0] parity_out
);
  // released ack line idles inactive
  assign ack_out = slot_in & ~refuse_in;
  assign parity_out = {^{id_in, cmd_in}, ^data_in[63:32], ^data_in[31:0]} ^ corrupt_in;
endmodule

// ### verification/sbec_checker.sv
// assertions on the ports of the bus error capture block
`timescale 1ns/100ps
`include "sbec_params.svh"
module sbec_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic own_addr_slot_in,
  input wire logic own_data_slot_in,
  input wire logic any_cycle_slot_in,
  input wire logic ack_in,
  input wire logic bad_wdata_in,
  input wire logic [63:0] bus_data_in,
  input wire logic [3:0] bus_cmd_in,
  input wire logic [2:0] bus_id_in,
  input wire logic [2:0] bus_parity_in,
  input wire logic ipr_sel_in,
  input wire logic ipr_wr_in,
  input wire logic [2:0] ipr_index_in,
  input wire logic [31:0] ipr_wdata_in,
  input wire logic [5:0] err_flags_out
);
  logic missing_acknowledge_flag, poison, bad, quiet;
  logic [5:0] f;
  assign f = err_flags_out;
  assign missing_acknowledge_flag = (own_addr_slot_in | own_data_slot_in) & ~ack_in;
  assign poison = own_data_slot_in & bad_wdata_in;
  // even parity per group including its line
  assign bad = any_cycle_slot_in & (bus_parity_in[0] ^ (^bus_data_in[31:0])
    | bus_parity_in[1] ^ (^bus_data_in[63:32]) | bus_parity_in[2] ^ (^{bus_id_in, bus_cmd_in}));
  assign quiet = ~own_addr_slot_in & ~own_data_slot_in & ~any_cycle_slot_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_missing_acknowledge_flag_sets: assert property (missing_acknowledge_flag && !f[1] |=> f[0])
    else $error("missing ack flag not set");
  a_poison_blocks_missing_acknowledge_flag: assert property (f[1] && !f[0] && !ipr_sel_in |=> !f[0])
    else $error("missing ack flag set after poison");
  a_poison_sets: assert property (poison |=> f[1])
    else $error("poison flag not set");
  a_lost_outgoing: assert property ((missing_acknowledge_flag || poison) && (f[0] || f[1]) |=> f[2])
    else $error("lost outgoing flag not set");
  a_parity_sets: assert property (bad |=> f[3])
    else $error("parity flag not set");
  a_incon_sets: assert property (bad && ack_in && !f[3] |=> f[4] && f[3])
    else $error("inconsistent flag not set");
  a_incon_held_off: assert property (f[3] && !f[4] && !ipr_sel_in |=> !f[4])
    else $error("inconsistent flag set late");
  a_lost_parity: assert property (bad && f[3] |=> f[5])
    else $error("lost parity flag not set");
  a_w1c_clear: assert property (ipr_sel_in && ipr_wr_in && quiet &&
    ipr_index_in == `SBEC_IDX_STATUS |=> f == ($past(f) & ~$past(ipr_wdata_in[5:0])))
    else $error("status clear wrong");
endmodule

// ### verification/sbec_tb_top.sv
// self-checking bench for the bus error capture block
`timescale 1ns/100ps
`include "sbec_params.svh"
bind sbec_top sbec_checker chk (.clk_in, .rstn_in, .own_addr_slot_in, .own_data_slot_in,
  .any_cycle_slot_in, .ack_in, .bad_wdata_in, .bus_data_in, .bus_cmd_in, .bus_id_in,
  .bus_parity_in, .ipr_sel_in, .ipr_wr_in, .ipr_index_in, .ipr_wdata_in, .err_flags_out);
module sbec_tb_top
  import sbec_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic oa = 1'b0, od = 1'b0, anys = 1'b0, bw = 1'b0, nak = 1'b0, sel = 1'b0, wr = 1'b0;
  logic [2:0] idx = 3'h0, cor = 3'h0, id = 3'h0, si, sp, par;
  logic [63:0] dat = 64'h0, sd;
  logic [3:0] cmd = 4'h0, sc;
  logic [7:0] be = 8'h0, sb;
  logic [1:0] len = 2'h0, sl;
  sbec_word_t wd = 32'h0, rd, ea, ec, ei, eh, el;
  logic ack, ipr_ack;
  logic [5:0] flags;
  int miscompares = 0, n_tests = 0, cycles = 0;
  sbec_word_t exp_q[$];
  sbec_top uut (.clk_in, .rstn_in, .own_addr_slot_in(oa), .own_data_slot_in(od),
    .any_cycle_slot_in(anys), .ack_in(ack), .bad_wdata_in(bw), .bus_data_in(dat),
    .bus_cmd_in(cmd), .bus_id_in(id), .bus_parity_in(par), .own_byte_en_in(be),
    .own_len_in(len), .ipr_sel_in(sel), .ipr_wr_in(wr), .ipr_index_in(idx),
    .ipr_wdata_in(wd), .ipr_rdata_out(rd), .ipr_ack_out(ipr_ack), .err_flags_out(flags));
  sbec_bus_agent agent (.slot_in(anys), .refuse_in(nak), .corrupt_in(cor), .data_in(dat),
    .cmd_in(cmd), .id_in(id), .ack_out(ack), .parity_out(par));
  initial forever #12.5 clk_in = ~clk_in;
  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input sbec_word_t seen, input sbec_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic sbec_word_t oc();
    return {sl, 14'h0, sb, 1'b0, si, sc};
  endfunction
  function automatic sbec_word_t ic();
    return {21'h0, {^{si, sc}, ^sd[63:32], ^sd[31:0]} ^ sp, 1'b0, si, sc};
  endfunction
  // register access; reads note the expected word, writes expect zero
  task automatic op(input logic w, input logic [2:0] i, input sbec_word_t d);
    @(posedge clk_in);
    {sel, wr, idx, wd} <= {1'b1, w, i, d};
    exp_q.push_back(w ? 32'h0 : d);
    @(posedge clk_in);
    sel <= 1'b0;
  endtask
  // one bus cycle: k 0 other agent, 1 own address, 2 own data
  task automatic cyc(input logic [1:0] k, input logic b, input logic n, input logic [2:0] c);
    sd = {$urandom(), $urandom()};
    {sc, si, sb, sl} = 17'($urandom());
    sp = c;
    @(posedge clk_in);
    {oa, od, anys, bw, nak, cor} <= {k == 2'h1, k == 2'h2, 1'b1, b, n, c};
    {dat, cmd, id, be, len} <= {sd, sc, si, sb, sl};
    @(posedge clk_in);
    {oa, od, anys, bw, nak, cor} <= 8'h0;
    dat <= ~sd;
  endtask
  always @(negedge clk_in) begin
    if (ipr_ack === 1'b1) begin
      chk(rd, exp_q.pop_front());
    end
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'hF037));
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    op(1'b1, 3'h0, 32'h3F);
    op(1'b0, 3'h0, 32'h0);
    cyc(2'h1, 1'b0, 1'b0, 3'h0);
    ea = sd[31:0];
    ec = oc();
    op(1'b0, 3'h1, ea);
    op(1'b1, 3'h1, 32'hFFFF_FFFF);
    op(1'b0, 3'h1, ea);
    op(1'b0, 3'h2, ec);
    // refused data cycle, then later address cycles while locked
    cyc(2'h2, 1'b0, 1'b1, 3'h0);
    cyc(2'h1, 1'b0, 1'b0, 3'h0);
    cyc(2'h1, 1'b0, 1'b1, 3'h0);
    op(1'b0, 3'h0, 32'h5);
    op(1'b0, 3'h1, ea);
    op(1'b0, 3'h2, ec);
    op(1'b1, 3'h0, 32'h0);
    op(1'b0, 3'h0, 32'h5);
    op(1'b1, 3'h0, 32'h4);
    op(1'b0, 3'h0, 32'h1);
    op(1'b1, 3'h0, 32'h1);
    cyc(2'h1, 1'b0, 1'b0, 3'h0);
    ea = sd[31:0];
    op(1'b0, 3'h1, ea);
    cyc(2'h2, 1'b1, 1'b0, 3'h0);
    op(1'b0, 3'h0, 32'h2);
    cyc(2'h2, 1'b0, 1'b1, 3'h0);
    op(1'b0, 3'h0, 32'h6);
    op(1'b0, 3'h1, ea);
    op(1'b1, 3'h0, 32'h3F);
    cyc(2'h2, 1'b1, 1'b1, 3'h0);
    op(1'b0, 3'h0, 32'h3);
    op(1'b1, 3'h0, 32'h3F);
    // parity failures on other agents' cycles
    cyc(2'h0, 1'b0, 1'b0, 3'h1);
    {ei, eh, el} = {ic(), sd};
    cyc(2'h0, 1'b0, 1'b0, 3'h6);
    op(1'b0, 3'h0, 32'h38);
    op(1'b0, 3'h3, ei);
    op(1'b0, 3'h4, eh);
    op(1'b0, 3'h5, el);
    op(1'b1, 3'h0, 32'h3F);
    cyc(2'h0, 1'b0, 1'b1, 3'h2);
    cyc(2'h0, 1'b0, 1'b0, 3'h1);
    op(1'b0, 3'h0, 32'h28);
    op(1'b0, 3'h7, 32'h0);
    // flags survive a reset in mid-run
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    op(1'b0, 3'h0, 32'h28);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk({26'h0, flags}, 32'h28);
    tally_and_finish();
  end
endmodule
